//--- include/modem_notify_pkg.sv
/*
 Constants, types and character strings shared by the modem call-out controller.
 Assumes a 25 MHz system clock and an external AT modem set to numeric result codes.
*/
package modem_notify_pkg;
	// ----------------------------------------
	// Timing
	// ----------------------------------------
	localparam int CLK_HZ = 25_000_000;
	localparam int MINUTE_S = 60;
	localparam int MINUTE_CYCLES_DEF = CLK_HZ * MINUTE_S;
	localparam int REPLY_TIMEOUT_MS = 3000;
	localparam int REPLY_CYCLES_DEF = (CLK_HZ / 1000) * REPLY_TIMEOUT_MS;
	localparam int PAGER_PAUSE_MS = 2000;
	localparam int PAUSE_CYCLES_DEF = (CLK_HZ / 1000) * PAGER_PAUSE_MS;
	localparam logic [5:0] PING_MIN = 6'h05;
	localparam logic [5:0] REINIT_MIN = 6'h0a;
	localparam logic [5:0] DELAY_MIN = 6'h01;
	localparam logic [5:0] DELAY_MAX = 6'h3c;
	localparam logic [1:0] REINIT_TRIES = 2'h3;

	// ----------------------------------------
	// Register map
	// ----------------------------------------
	localparam logic [7:0] ADDR_CTRL = 8'h00;
	localparam logic [7:0] ADDR_G1CFG = 8'h04;
	localparam logic [7:0] ADDR_G2CFG = 8'h08;
	localparam logic [7:0] ADDR_BUF = 8'h0c;
	localparam logic [7:0] ADDR_LEN = 8'h10;
	localparam logic [7:0] ADDR_STATUS = 8'h14;
	localparam int CTRL_ENABLE = 0;
	localparam int CTRL_PAGER1 = 1;
	localparam int CTRL_PAGER2 = 2;
	localparam logic [2:0] CTRL_RESET = 3'h1;

	// ----------------------------------------
	// Message buffer
	// ----------------------------------------
	localparam int PHONE_MAX = 20;
	localparam int TEXT_MAX = 40;
	localparam int BUF_DEPTH = PHONE_MAX + TEXT_MAX;
	localparam logic [5:0] TEXT_BASE = 6'h14;

	// ----------------------------------------
	// Characters
	// ----------------------------------------
	localparam logic [7:0] CH_SPACE = 8'h20;
	localparam logic [7:0] CH_LF = 8'h0a;
	localparam logic [7:0] CH_CR = 8'h0d;
	localparam logic [7:0] RES_OK = 8'h30;
	localparam logic [7:0] RES_OK_TEXT = 8'h4f;
	localparam logic [7:0] RES_CONNECT = 8'h31;
	localparam logic [7:0] RES_RING = 8'h32;
	localparam logic [7:0] RES_NO_CARRIER = 8'h33;
	localparam logic [7:0] KEY_ALL = 8'h01;
	localparam logic [7:0] KEY_BATT = 8'h02;
	localparam logic [7:0] KEY_METERS = 8'h0d;
	localparam logic [7:0] KEY_HIST = 8'h10;
	localparam logic [7:0] KEY_RESET = 8'h12;

	// ----------------------------------------
	// Command strings
	// ----------------------------------------
	localparam logic [6:0] LEN_PING = 7'h03;
	localparam logic [6:0] LEN_INIT = 7'h0f;
	localparam logic [6:0] LEN_DIAL = 7'h07;
	localparam logic [6:0] LEN_HANG = 7'h05;
	localparam logic [8*3-1:0] STR_PING = "AT\r";
	localparam logic [8*15-1:0] STR_INIT = "ATE0V0X0&D0&K0\r";
	localparam logic [8*7-1:0] STR_DIAL1 = "ATDTS0\r";
	localparam logic [8*7-1:0] STR_DIAL2 = "ATDTS1\r";
	localparam logic [8*5-1:0] STR_HANG = "ATH0\r";
	localparam logic [6:0] MSG_TAIL = 7'h03;

	// ----------------------------------------
	// Types
	// ----------------------------------------
	typedef struct packed {
		logic [5:0] delay_min;
		logic [7:0] attempts;
	} grp_cfg_t;

	typedef enum logic [1:0] {
		LOG_NOTIFY_OK = 2'b00,
		LOG_NOTIFY_FAIL = 2'b01,
		LOG_MODEM_FAIL = 2'b10
	} log_kind_t;

	typedef struct packed {
		log_kind_t kind;
		logic grp;
	} log_evt_t;

	typedef enum logic [2:0] {
		SEQ_PING = 3'b000,
		SEQ_INIT = 3'b001,
		SEQ_DIAL = 3'b010,
		SEQ_MSG = 3'b011,
		SEQ_PAGE = 3'b100,
		SEQ_HANG = 3'b101
	} seq_t;

	typedef enum logic [3:0] {
		ST_IDLE = 4'b0000,
		ST_PING = 4'b0001,
		ST_PING_WAIT = 4'b0010,
		ST_INIT = 4'b0011,
		ST_INIT_WAIT = 4'b0100,
		ST_DIAL = 4'b0101,
		ST_DIAL_WAIT = 4'b0110,
		ST_PAUSE = 4'b0111,
		ST_PAGE = 4'b1000,
		ST_MSG = 4'b1001,
		ST_HANG = 4'b1010,
		ST_ANS_WAIT = 4'b1011,
		ST_SESSION = 4'b1100
	} state_t;
endpackage

//--- hw/minute_timer.sv
/*
 Minute-resolution countdown used for retry delays and modem supervision.
 Assumes a one-cycle minute tick from the parent; first minute may be short.
*/
`timescale 1ns/1ns
module minute_timer #(
	parameter int W = 6
)(
	input wire logic i_clk,
	input wire logic i_srst,
	input wire logic i_tick,
	input wire logic i_load,
	input wire logic i_stop,
	input wire logic [W-1:0] i_minutes,
	output logic o_ready
);
	logic [W-1:0] cnt_reg;
	logic armed_reg;

	always_ff @(posedge i_clk)
	begin
		if (i_srst)
		begin
			cnt_reg <= '0;
			armed_reg <= 1'b0;
		end
		else if (i_load)
		begin
			cnt_reg <= i_minutes;
			armed_reg <= 1'b1;
		end
		else if (i_stop)
			armed_reg <= 1'b0;
		else if (i_tick && cnt_reg != '0)
			cnt_reg <= cnt_reg - 1'b1;
	end

	assign o_ready = !armed_reg || cnt_reg == '0;
endmodule // minute_timer

//--- hw/modem_notify_ctrl.sv
/*
 Call answer, call-out and housekeeping controller for an external AT modem.
 Assumes a byte UART outside (valid/ready out, valid in), a Wishbone classic
 master for setup, and a modem set to numeric, basic result codes.
*/
`timescale 1ns/1ns
module modem_notify_ctrl
	import modem_notify_pkg::*;
#(
	parameter int MINUTE_CYCLES = MINUTE_CYCLES_DEF,
	parameter int REPLY_CYCLES = REPLY_CYCLES_DEF,
	parameter int PAUSE_CYCLES = PAUSE_CYCLES_DEF
)(
	input wire logic I_CLK,
	input wire logic I_SRST,
	input wire logic I_WB_CYC,
	input wire logic I_WB_STB,
	input wire logic I_WB_WE,
	input wire logic [7:0] I_WB_ADR,
	input wire logic [3:0] I_WB_SEL,
	input wire logic [31:0] I_WB_DAT,
	output logic [31:0] O_WB_DAT,
	output logic O_WB_ACK,
	input wire logic [1:0] I_EVT,
	input wire logic I_KEY_SWITCH,
	input wire logic I_COMM_MODE_CHG,
	input wire logic I_RX_VALID,
	input wire logic [7:0] I_RX_DATA,
	output logic O_TX_VALID,
	output logic [7:0] O_TX_DATA,
	input wire logic I_TX_READY,
	output logic [3:0] O_SHOW,
	output logic O_LOG_VALID,
	output log_evt_t O_LOG,
	output logic O_SESSION,
	output logic O_CALLOUT_DIS
);
	state_t state_reg;
	logic ack_reg;
	logic [31:0] rdat_reg;
	logic [2:0] ctrl_reg;
	grp_cfg_t cfg_reg [2];
	logic [4:0] plen_reg;
	logic [5:0] tlen_reg;
	logic [7:0] buf_reg [BUF_DEPTH];
	logic [31:0] pre_reg;
	logic tick_reg;
	logic [31:0] wait_reg;
	logic [1:0] pend_reg;
	logic [7:0] left_reg [2];
	logic grp_reg;
	logic dis_reg;
	logic hk_stop_reg;
	logic [1:0] fails_reg;
	logic start_reg;
	seq_t seq_reg;
	logic busy_reg;
	logic done_reg;
	logic [6:0] idx_reg;
	logic [7:0] tx_reg;
	logic [3:0] show_reg;
	logic log_v_reg;
	log_evt_t log_reg;

	logic wb_req;
	logic wb_wr;
	logic rx_sig;
	logic rx_ok;
	logic timeout;
	logic abort;
	logic [1:0] g_ready;
	logic [1:0] can_call;
	logic hk_ready;
	logic fail_now;
	logic ok_now;
	logic [1:0] t_load;
	logic hk_load;
	logic [5:0] hk_min;
	logic [5:0] g_delay [2];

	// ----------------------------------------
	// Wishbone slave
	// ----------------------------------------
	assign wb_req = I_WB_CYC && I_WB_STB && !ack_reg;
	assign wb_wr = wb_req && I_WB_WE;

	always_ff @(posedge I_CLK)
	begin
		if (I_SRST)
			ack_reg <= 1'b0;
		else
			ack_reg <= wb_req;
	end

	always_ff @(posedge I_CLK)
	begin
		if (I_SRST)
			rdat_reg <= '0;
		else if (wb_req && !I_WB_WE)
		begin
			unique case (I_WB_ADR)
				ADDR_CTRL: rdat_reg <= {29'h0000_0000, ctrl_reg};
				ADDR_G1CFG: rdat_reg <= {18'h0_0000, cfg_reg[0]};
				ADDR_G2CFG: rdat_reg <= {18'h0_0000, cfg_reg[1]};
				ADDR_LEN: rdat_reg <= {18'h0_0000, tlen_reg, 3'h0, plen_reg};
				ADDR_STATUS: rdat_reg <= {21'h00_0000, hk_stop_reg, fails_reg, O_SESSION, dis_reg,
					pend_reg, state_reg};
				default: rdat_reg <= '0;
			endcase
		end
	end

	assign O_WB_ACK = ack_reg;
	assign O_WB_DAT = rdat_reg;

	always_ff @(posedge I_CLK)
	begin
		if (I_SRST)
		begin
			ctrl_reg <= CTRL_RESET;
			cfg_reg[0] <= '0;
			cfg_reg[1] <= '0;
			plen_reg <= '0;
			tlen_reg <= '0;
		end
		else if (wb_wr)
		begin
			if (I_WB_ADR == ADDR_G1CFG && I_WB_SEL[0])
				cfg_reg[0].attempts <= I_WB_DAT[7:0];
			if (I_WB_ADR == ADDR_G1CFG && I_WB_SEL[1])
				cfg_reg[0].delay_min <= I_WB_DAT[13:8];
			if (I_WB_ADR == ADDR_G2CFG && I_WB_SEL[0])
				cfg_reg[1].attempts <= I_WB_DAT[7:0];
			if (I_WB_ADR == ADDR_G2CFG && I_WB_SEL[1])
				cfg_reg[1].delay_min <= I_WB_DAT[13:8];
			if (I_WB_ADR == ADDR_CTRL && I_WB_SEL[0])
				ctrl_reg <= I_WB_DAT[2:0];
			if (I_WB_ADR == ADDR_LEN && I_WB_SEL[0] && I_WB_DAT[4:0] <= 5'(PHONE_MAX))
				plen_reg <= I_WB_DAT[4:0];
			if (I_WB_ADR == ADDR_LEN && I_WB_SEL[1] && I_WB_DAT[13:8] <= 6'(TEXT_MAX))
				tlen_reg <= I_WB_DAT[13:8];
		end
	end

	// Buffer is not reset; software loads it before enabling
	always_ff @(posedge I_CLK)
	begin
		if (wb_wr && I_WB_ADR == ADDR_BUF && I_WB_SEL[1:0] == 2'h3 && I_WB_DAT[13:8] < 6'(BUF_DEPTH))
			buf_reg[I_WB_DAT[13:8]] <= I_WB_DAT[7:0];
	end

	// ----------------------------------------
	// Minute prescaler and timers
	// ----------------------------------------
	// minute tick from system clock
	always_ff @(posedge I_CLK)
	begin
		if (I_SRST || pre_reg == 32'(MINUTE_CYCLES - 1))
			pre_reg <= '0;
		else
			pre_reg <= pre_reg + 1'b1;
	end

	always_ff @(posedge I_CLK)
	begin
		if (I_SRST)
			tick_reg <= 1'b0;
		else
			tick_reg <= pre_reg == 32'(MINUTE_CYCLES - 1);
	end

	always_comb
	begin
		for (int g = 0; g < 2; g++)
		begin
			g_delay[g] = cfg_reg[g].delay_min;
			if (g_delay[g] < DELAY_MIN)
				g_delay[g] = DELAY_MIN;
			else if (g_delay[g] > DELAY_MAX)
				g_delay[g] = DELAY_MAX;
		end
	end

	for (genvar g = 0; g < 2; g++)
	begin : g_timer
		minute_timer #(.W(6)) u_retry (
			.i_clk(I_CLK),
			.i_srst(I_SRST),
			.i_tick(tick_reg),
			.i_load(t_load[g]),
			.i_stop(I_EVT[g] && !pend_reg[g]),
			.i_minutes(g_delay[g]),
			.o_ready(g_ready[g])
		);
	end

	minute_timer #(.W(6)) u_house (
		.i_clk(I_CLK),
		.i_srst(I_SRST),
		.i_tick(tick_reg),
		.i_load(hk_load),
		.i_stop(1'b0),
		.i_minutes(hk_min),
		.o_ready(hk_ready)
	);

	// ----------------------------------------
	// Transmit sequencer
	// ----------------------------------------
	function automatic logic [6:0] seq_len(seq_t s);
		unique case (s)
			SEQ_PING: return LEN_PING;
			SEQ_INIT: return LEN_INIT;
			SEQ_DIAL: return LEN_DIAL;
			SEQ_MSG: return 7'(plen_reg) + 7'(tlen_reg) + MSG_TAIL;
			SEQ_PAGE: return 7'(tlen_reg) + 7'h01;
			default: return LEN_HANG;
		endcase
	endfunction

	function automatic logic [7:0] seq_byte(seq_t s, logic [6:0] i);
		logic [6:0] tend;
		tend = 7'(plen_reg) + 7'(tlen_reg) + 7'h01;
		unique case (s)
			SEQ_PING: return STR_PING[(LEN_PING - 7'h01 - i) * 8 +: 8];
			SEQ_INIT: return STR_INIT[(LEN_INIT - 7'h01 - i) * 8 +: 8];
			SEQ_DIAL: return grp_reg ? STR_DIAL2[(LEN_DIAL - 7'h01 - i) * 8 +: 8]
				: STR_DIAL1[(LEN_DIAL - 7'h01 - i) * 8 +: 8];
			SEQ_MSG:
			begin
				if (i < 7'(plen_reg))
					return buf_reg[6'(i)];
				else if (i == 7'(plen_reg))
					return CH_SPACE;
				else if (i < tend)
					return buf_reg[6'(i - 7'(plen_reg) - 7'h01) + TEXT_BASE];
				else if (i == tend)
					return CH_LF;
				else
					return CH_CR;
			end
			SEQ_PAGE: return (i < 7'(tlen_reg)) ? buf_reg[6'(i) + TEXT_BASE] : CH_CR;
			default: return STR_HANG[(LEN_HANG - 7'h01 - i) * 8 +: 8];
		endcase
	endfunction

	always_ff @(posedge I_CLK)
	begin
		if (I_SRST)
		begin
			busy_reg <= 1'b0;
			done_reg <= 1'b0;
			idx_reg <= '0;
			tx_reg <= '0;
		end
		else
		begin
			done_reg <= 1'b0;
			if (start_reg)
			begin
				busy_reg <= 1'b1;
				idx_reg <= '0;
				tx_reg <= seq_byte(seq_reg, 7'h00);
			end
			else if (busy_reg && I_TX_READY)
			begin
				if (idx_reg == seq_len(seq_reg) - 7'h01)
				begin
					busy_reg <= 1'b0;
					done_reg <= 1'b1;
				end
				else
				begin
					idx_reg <= idx_reg + 7'h01;
					tx_reg <= seq_byte(seq_reg, idx_reg + 7'h01);
				end
			end
		end
	end

	assign O_TX_VALID = busy_reg;
	assign O_TX_DATA = tx_reg;

	// ----------------------------------------
	// Reply decode
	// ----------------------------------------
	assign rx_sig = I_RX_VALID && I_RX_DATA != CH_CR && I_RX_DATA != CH_LF;
	assign rx_ok = I_RX_DATA == RES_OK || I_RX_DATA == RES_OK_TEXT;
	assign timeout = wait_reg == 32'(REPLY_CYCLES - 1);
	assign abort = I_KEY_SWITCH || (state_reg == ST_SESSION && I_RX_VALID && I_RX_DATA == KEY_RESET);
	assign can_call = (ctrl_reg[CTRL_ENABLE] && !dis_reg) ? (pend_reg & g_ready) : 2'b00;
	assign fail_now = (state_reg == ST_DIAL_WAIT && (timeout || (rx_sig && I_RX_DATA != RES_CONNECT)))
		|| (state_reg == ST_PAGE && done_reg);
	assign ok_now = state_reg == ST_DIAL_WAIT && rx_sig && I_RX_DATA == RES_CONNECT
		&& !ctrl_reg[CTRL_PAGER1 + 32'(grp_reg)];

	always_ff @(posedge I_CLK)
	begin
		// Restarted per wait; a free count could pass its limit before the wait began
		if (I_SRST || start_reg || done_reg || state_reg == ST_IDLE)
			wait_reg <= '0;
		else
			wait_reg <= wait_reg + 1'b1;
	end

	// ----------------------------------------
	// Pending calls per group
	// ----------------------------------------
	always_comb
	begin
		t_load = 2'b00;
		if (fail_now && left_reg[grp_reg] != 8'h01)
			t_load[grp_reg] = 1'b1;
	end

	always_ff @(posedge I_CLK)
	begin
		if (I_SRST)
		begin
			pend_reg <= '0;
			left_reg[0] <= '0;
			left_reg[1] <= '0;
		end
		else
		begin
			if (abort)
				pend_reg <= '0;
			else if (ok_now)
				pend_reg[grp_reg] <= 1'b0;
			else if (fail_now)
			begin
				left_reg[grp_reg] <= left_reg[grp_reg] - 8'h01;
				if (left_reg[grp_reg] == 8'h01)
					pend_reg[grp_reg] <= 1'b0;
			end
			// New alarm wins over a clear in the same cycle
			for (int g = 0; g < 2; g++)
				if (I_EVT[g] && cfg_reg[g].attempts != 8'h00)
				begin
					pend_reg[g] <= 1'b1;
					left_reg[g] <= cfg_reg[g].attempts;
				end
		end
	end

	// ----------------------------------------
	// Main sequencing
	// ----------------------------------------
	always_ff @(posedge I_CLK)
	begin
		if (I_SRST)
		begin
			state_reg <= ST_IDLE;
			start_reg <= 1'b0;
			seq_reg <= SEQ_PING;
			grp_reg <= 1'b1;
			dis_reg <= 1'b0;
			fails_reg <= '0;
			hk_stop_reg <= 1'b0;
			hk_load <= 1'b0;
			hk_min <= PING_MIN;
			log_v_reg <= 1'b0;
			log_reg <= '0;
			show_reg <= '0;
		end
		else
		begin
			start_reg <= 1'b0;
			hk_load <= 1'b0;
			log_v_reg <= 1'b0;
			show_reg <= '0;
			if (I_COMM_MODE_CHG)
				hk_stop_reg <= 1'b1;
			else if (wb_wr && I_WB_ADR == ADDR_CTRL)
				hk_stop_reg <= 1'b0;
			unique case (state_reg)
				ST_IDLE:
				begin
					if (rx_sig && I_RX_DATA == RES_RING)
						state_reg <= ST_ANS_WAIT;
					else if (rx_sig && I_RX_DATA == RES_CONNECT)
						state_reg <= ST_SESSION;
					else if (can_call != 2'b00)
					begin
						grp_reg <= (can_call == 2'b11) ? !grp_reg : can_call[1];
						seq_reg <= SEQ_DIAL;
						start_reg <= 1'b1;
						state_reg <= ST_DIAL;
					end
					else if (hk_ready && !hk_stop_reg)
					begin
						// periodic ping; slow re-init when disabled
						seq_reg <= dis_reg ? SEQ_INIT : SEQ_PING;
						start_reg <= 1'b1;
						state_reg <= dis_reg ? ST_INIT : ST_PING;
					end
				end
				ST_PING:
					if (done_reg)
						state_reg <= ST_PING_WAIT;
				ST_PING_WAIT:
					if (rx_sig || timeout)
					begin
						// bad or missing reply starts re-init
						if (rx_sig && rx_ok)
						begin
							hk_min <= PING_MIN;
							hk_load <= 1'b1;
							state_reg <= ST_IDLE;
						end
						else
						begin
							fails_reg <= '0;
							seq_reg <= SEQ_INIT;
							start_reg <= 1'b1;
							state_reg <= ST_INIT;
						end
					end
				ST_INIT:
					if (done_reg)
						state_reg <= ST_INIT_WAIT;
				ST_INIT_WAIT:
					if (rx_sig || timeout)
					begin
						if (rx_sig && rx_ok)
						begin
							dis_reg <= 1'b0;
							fails_reg <= '0;
							hk_min <= PING_MIN;
							hk_load <= 1'b1;
							state_reg <= ST_IDLE;
						end
						else
						begin
							log_v_reg <= 1'b1;
							log_reg <= '{kind: LOG_MODEM_FAIL, grp: 1'b0};
							if (!dis_reg && fails_reg + 2'h1 < REINIT_TRIES)
							begin
								fails_reg <= fails_reg + 2'h1;
								seq_reg <= SEQ_INIT;
								start_reg <= 1'b1;
								state_reg <= ST_INIT;
							end
							else
							begin
								dis_reg <= 1'b1;
								fails_reg <= REINIT_TRIES;
								hk_min <= REINIT_MIN;
								hk_load <= 1'b1;
								state_reg <= ST_IDLE;
							end
						end
					end
				ST_DIAL:
					if (done_reg)
						state_reg <= ctrl_reg[CTRL_PAGER1 + 32'(grp_reg)] ? ST_PAUSE : ST_DIAL_WAIT;
				ST_DIAL_WAIT:
				begin
					if (ok_now)
					begin
						log_v_reg <= 1'b1;
						log_reg <= '{kind: LOG_NOTIFY_OK, grp: grp_reg};
						seq_reg <= SEQ_MSG;
						start_reg <= 1'b1;
						state_reg <= ST_MSG;
					end
					else if (fail_now || abort)
					begin
						log_v_reg <= fail_now;
						log_reg <= '{kind: LOG_NOTIFY_FAIL, grp: grp_reg};
						seq_reg <= SEQ_HANG;
						start_reg <= 1'b1;
						state_reg <= ST_HANG;
					end
				end
				ST_PAUSE:
					if (wait_reg == 32'(PAUSE_CYCLES - 1) || abort)
					begin
						seq_reg <= abort ? SEQ_HANG : SEQ_PAGE;
						start_reg <= 1'b1;
						state_reg <= abort ? ST_HANG : ST_PAGE;
					end
				ST_PAGE:
					if (done_reg)
					begin
						log_v_reg <= 1'b1;
						log_reg <= '{kind: LOG_NOTIFY_FAIL, grp: grp_reg};
						seq_reg <= SEQ_HANG;
						start_reg <= 1'b1;
						state_reg <= ST_HANG;
					end
				ST_MSG:
					if (done_reg)
					begin
						seq_reg <= SEQ_HANG;
						start_reg <= 1'b1;
						state_reg <= ST_HANG;
					end
				ST_HANG:
					if (done_reg)
						state_reg <= ST_IDLE;
				ST_ANS_WAIT:
					if (rx_sig && I_RX_DATA == RES_CONNECT)
						state_reg <= ST_SESSION;
					else if (timeout || (rx_sig && I_RX_DATA != RES_RING))
						state_reg <= ST_IDLE;
				ST_SESSION:
					if (I_RX_VALID)
					begin
						show_reg <= {I_RX_DATA == KEY_HIST, I_RX_DATA == KEY_METERS,
							I_RX_DATA == KEY_BATT, I_RX_DATA == KEY_ALL};
						if (I_RX_DATA == RES_NO_CARRIER)
							state_reg <= ST_IDLE;
					end
				default:
					state_reg <= ST_IDLE;
			endcase
		end
	end

	assign O_SHOW = show_reg;
	assign O_LOG_VALID = log_v_reg;
	assign O_LOG = log_reg;
	assign O_SESSION = state_reg == ST_SESSION;
	assign O_CALLOUT_DIS = dis_reg;
endmodule // modem_notify_ctrl

//--- bench/modem_notify_ctrl_properties.sv
/* Port checker for the modem controller.
 Assumes binding to every modem_notify_ctrl instance. */
`timescale 1ns/1ns
module modem_notify_ctrl_properties
	import modem_notify_pkg::*;
(
	input wire logic I_CLK,
	input wire logic I_SRST,
	input wire logic I_WB_CYC,
	input wire logic I_WB_STB,
	input wire logic O_WB_ACK,
	input wire logic I_RX_VALID,
	input wire logic [7:0] I_RX_DATA,
	input wire logic O_TX_VALID,
	input wire logic [7:0] O_TX_DATA,
	input wire logic I_TX_READY,
	input wire logic [3:0] O_SHOW,
	input wire logic O_LOG_VALID,
	input wire log_evt_t O_LOG,
	input wire logic O_SESSION,
	input wire logic O_CALLOUT_DIS
);
	default clocking dc @(posedge I_CLK); endclocking
	default disable iff (I_SRST);
	// ----------------------------------------
	// Assertions
	// ----------------------------------------
	ack_one_wait_a: assert property (I_WB_CYC && I_WB_STB && !O_WB_ACK |=> O_WB_ACK)
		else $error("ack late");
	ack_pulse_a: assert property (O_WB_ACK |=> !O_WB_ACK)
		else $error("ack too long");
	tx_hold_a: assert property (O_TX_VALID && !I_TX_READY |=> O_TX_VALID && $stable(O_TX_DATA))
		else $error("byte dropped");
	show_all_a: assert property (I_RX_VALID && O_SESSION && I_RX_DATA == KEY_ALL |-> ##[1:2] O_SHOW[0])
		else $error("key not shown");
	show_session_a: assert property (O_SHOW != 4'h0 |-> $past(O_SESSION))
		else $error("show outside session");
	session_hold_a: assert property (O_SESSION && !(I_RX_VALID && I_RX_DATA == RES_NO_CARRIER) |=> O_SESSION)
		else $error("session lost");
	log_pulse_a: assert property (O_LOG_VALID |=> !O_LOG_VALID)
		else $error("log doubled");
	notify_enabled_a: assert property (O_LOG_VALID && O_LOG.kind == LOG_NOTIFY_OK |-> !O_CALLOUT_DIS)
		else $error("notify while disabled");
	cover property ($rose(O_SESSION));
	cover property ($rose(O_CALLOUT_DIS));
	cover property (O_LOG_VALID && O_LOG.kind == LOG_NOTIFY_FAIL);
endmodule // modem_notify_ctrl_properties

bind modem_notify_ctrl modem_notify_ctrl_properties u_props (.I_CLK(I_CLK), .I_SRST(I_SRST),
	.I_WB_CYC(I_WB_CYC), .I_WB_STB(I_WB_STB), .O_WB_ACK(O_WB_ACK), .I_RX_VALID(I_RX_VALID),
	.I_RX_DATA(I_RX_DATA), .O_TX_VALID(O_TX_VALID), .O_TX_DATA(O_TX_DATA), .I_TX_READY(I_TX_READY),
	.O_SHOW(O_SHOW), .O_LOG_VALID(O_LOG_VALID), .O_LOG(O_LOG), .O_SESSION(O_SESSION),
	.O_CALLOUT_DIS(O_CALLOUT_DIS));

//--- bench/modem_model.sv
/* Behavioural modem on the byte stream.
 Assumes the bench sets the reply code and injects caller bytes. */
`timescale 1ns/1ns
module modem_model
	import modem_notify_pkg::*;
(
	input wire logic i_clk,
	input wire logic i_tx_valid,
	input wire logic [7:0] i_tx_data,
	input wire logic i_slow,
	input wire logic [7:0] i_reply,
	input wire logic i_inj_valid,
	input wire logic [7:0] i_inj_data,
	output logic o_tx_ready,
	output logic o_rx_valid,
	output logic [7:0] o_rx_data
);
	logic [3:0] wait_reg = 4'h0;
	logic stall_reg = 1'b0;
	logic rx_valid_reg = 1'b0;
	logic [7:0] rx_data_reg = 8'h00;
	assign o_tx_ready = !stall_reg;
	assign o_rx_valid = rx_valid_reg;
	assign o_rx_data = rx_data_reg;
	// Slow mode stalls every other cycle
	always_ff @(posedge i_clk)
		stall_reg <= i_slow && !stall_reg;
	always_ff @(posedge i_clk)
	begin
		if (i_tx_valid && !stall_reg && i_tx_data == CH_CR)
			wait_reg <= 4'h8;
		else if (wait_reg != 4'h0)
			wait_reg <= wait_reg - 4'h1;
	end
	always_ff @(posedge i_clk)
	begin
		rx_valid_reg <= 1'b0;
		rx_data_reg <= ~rx_data_reg;
		if (wait_reg == 4'h1 && i_reply != 8'h00)
		begin
			rx_valid_reg <= 1'b1;
			rx_data_reg <= i_reply;
		end
		else if (i_inj_valid)
		begin
			rx_valid_reg <= 1'b1;
			rx_data_reg <= i_inj_data;
		end
	end
endmodule // modem_model

//--- bench/tb_modem_notify_ctrl.sv
/* Self-checking bench for the modem controller.
 Assumes modem_model and shortened minute timing. */
`timescale 1ns/1ns
module tb_modem_notify_ctrl;
	import modem_notify_pkg::*;
	logic clk = 1'b0;
	logic srst = 1'b1;
	logic cyc = 1'b0;
	logic stb = 1'b0;
	logic we = 1'b0;
	logic [7:0] adr = 8'h00;
	logic [31:0] wdat = 32'h0000_0000;
	logic [1:0] evt = 2'b00;
	logic key = 1'b0;
	logic mode = 1'b0;
	logic slow = 1'b0;
	logic [7:0] reply = RES_OK;
	logic inj_v = 1'b0;
	logic [7:0] inj_d = 8'h00;
	logic [31:0] rdat, q;
	logic ack, rx_v, tx_v, tx_rdy, log_v, sess, dis;
	logic [7:0] rx_d, tx_d;
	logic [3:0] show, show_acc;
	log_evt_t log_e;
	logic [7:0] txq[$];
	log_evt_t logq[$];
	logic [7:0] keys[4] = '{KEY_ALL, KEY_BATT, KEY_METERS, KEY_HIST};
	int num_errors = 0;
	int checked = 0;
	int cycles = 0;
	always #20 clk = !clk;
	modem_notify_ctrl #(.MINUTE_CYCLES(20), .REPLY_CYCLES(50), .PAUSE_CYCLES(10)) u_dut (.I_CLK(clk),
		.I_SRST(srst), .I_WB_CYC(cyc), .I_WB_STB(stb), .I_WB_WE(we), .I_WB_ADR(adr), .I_WB_SEL(4'hf),
		.I_WB_DAT(wdat), .O_WB_DAT(rdat), .O_WB_ACK(ack), .I_EVT(evt), .I_KEY_SWITCH(key),
		.I_COMM_MODE_CHG(mode), .I_RX_VALID(rx_v), .I_RX_DATA(rx_d), .O_TX_VALID(tx_v), .O_TX_DATA(tx_d),
		.I_TX_READY(tx_rdy), .O_SHOW(show), .O_LOG_VALID(log_v), .O_LOG(log_e), .O_SESSION(sess),
		.O_CALLOUT_DIS(dis));
	modem_model u_modem (.i_clk(clk), .i_tx_valid(tx_v), .i_tx_data(tx_d), .i_slow(slow), .i_reply(reply),
		.i_inj_valid(inj_v), .i_inj_data(inj_d), .o_tx_ready(tx_rdy), .o_rx_valid(rx_v), .o_rx_data(rx_d));
	// ----------------------------------------
	// Monitor and tasks
	// ----------------------------------------
	always @(posedge clk)
	begin
		cycles <= cycles + 1;
		if (tx_v && tx_rdy)
			txq.push_back(tx_d);
		if (log_v)
			logq.push_back(log_e);
		// Ceiling far above the longest supervision wait
		if (cycles > 30000)
		begin
			num_errors++;
			finish_test();
		end
	end
	task automatic finish_test();
		$display("errors %0d checks %0d", num_errors, checked);
		if (num_errors == 0 && checked > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		checked++;
		if (got !== exp)
		begin
			num_errors++;
			$display("[ERR] %0t got %h exp %h", $time, got, exp);
		end
	endtask
	task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
		@(posedge clk);
		cyc <= 1'b1;
		stb <= 1'b1;
		we <= w;
		adr <= a;
		wdat <= d;
		do @(posedge clk); while (ack !== 1'b1);
		q = rdat;
		cyc <= 1'b0;
		stb <= 1'b0;
	endtask
	task automatic exp_bytes(input logic [8*15-1:0] s, input int n);
		for (int i = n - 1; i >= 0; i--)
		begin
			while (txq.size() == 0) @(posedge clk);
			chk({24'h00_0000, txq.pop_front()}, {24'h00_0000, s[8*i +: 8]});
		end
	endtask
	task automatic exp_log(input logic [2:0] e, input logic [2:0] m);
		while (logq.size() == 0) @(posedge clk);
		chk({29'h0000_0000, logq.pop_front() & m}, {29'h0000_0000, e});
	endtask
	task automatic quiet(input int n);
		txq.delete();
		repeat (n) @(posedge clk);
		chk(txq.size(), 0);
	endtask
	// Caller byte, then three cycles of display pulses gathered
	task automatic inj(input logic [7:0] b);
		@(posedge clk);
		inj_v <= 1'b1;
		inj_d <= b;
		show_acc = 4'h0;
		@(posedge clk);
		inj_v <= 1'b0;
		repeat (3)
		begin
			@(posedge clk);
			show_acc = show_acc | show;
		end
	endtask
	task automatic stop_ping();
		mode <= 1'b1;
		@(posedge clk);
		mode <= 1'b0;
	endtask
	task automatic call1();
		evt <= 2'b01;
		@(posedge clk);
		evt <= 2'b00;
		exp_bytes(STR_DIAL1, 7);
		exp_bytes(STR_HANG, 5);
	endtask
	// ----------------------------------------
	// Sequence
	// ----------------------------------------
	initial
	begin
		repeat (16) @(posedge clk);
		srst <= 1'b0;
		wb(1'b0, ADDR_CTRL, 32'h0000_0000);
		chk(q, 32'h0000_0001);
		wb(1'b0, 8'h18, 32'h0000_0000);
		chk(q, 32'h0000_0000);
		exp_bytes(STR_PING, 3);
		// Let the first ping's reply pass before spoiling replies
		repeat (12) @(posedge clk);
		reply <= RES_NO_CARRIER;
		exp_bytes(STR_PING, 3);
		repeat (3) exp_bytes(STR_INIT, 15);
		repeat (3) exp_log({LOG_MODEM_FAIL, 1'b0}, 3'h6);
		repeat (2) @(posedge clk);
		chk(dis, 1'b1);
		reply <= RES_OK;
		exp_bytes(STR_INIT, 15);
		repeat (20) @(posedge clk);
		chk(dis, 1'b0);
		stop_ping();
		wb(1'b1, ADDR_BUF, 32'h0000_0031);
		wb(1'b1, ADDR_BUF, 32'h0000_0132);
		wb(1'b1, ADDR_BUF, 32'h0000_1441);
		wb(1'b1, ADDR_BUF, 32'h0000_1542);
		wb(1'b1, ADDR_LEN, 32'h0000_0202);
		wb(1'b1, ADDR_G1CFG, 32'h0000_0102);
		wb(1'b0, ADDR_G1CFG, 32'h0000_0000);
		chk(q, 32'h0000_0102);
		wb(1'b1, ADDR_G2CFG, 32'h0000_0101);
		logq.delete();
		slow <= 1'b1;
		reply <= RES_CONNECT;
		evt <= 2'b01;
		@(posedge clk);
		evt <= 2'b00;
		exp_bytes(STR_DIAL1, 7);
		exp_log({LOG_NOTIFY_OK, 1'b0}, 3'h7);
		// Later commands answered with OK, not a stray connect
		reply <= RES_OK;
		exp_bytes({"12", CH_SPACE, "AB", CH_LF, CH_CR}, 7);
		exp_bytes(STR_HANG, 5);
		slow <= 1'b0;
		quiet(100);
		reply <= RES_NO_CARRIER;
		evt <= 2'b11;
		@(posedge clk);
		evt <= 2'b00;
		// Last call was group one, so group two goes first
		exp_bytes(STR_DIAL2, 7);
		exp_bytes(STR_HANG, 5);
		exp_bytes(STR_DIAL1, 7);
		exp_bytes(STR_HANG, 5);
		exp_bytes(STR_DIAL1, 7);
		exp_bytes(STR_HANG, 5);
		quiet(150);
		for (int r = 0; r < 3; r++)
			exp_log({LOG_NOTIFY_FAIL, r == 0}, 3'h7);
		// Mode change held over the write, so supervision stays stopped
		mode <= 1'b1;
		wb(1'b1, ADDR_CTRL, 32'h0000_0005);
		mode <= 1'b0;
		reply <= RES_OK;
		evt <= 2'b10;
		@(posedge clk);
		evt <= 2'b00;
		exp_bytes(STR_DIAL2, 7);
		exp_bytes({"AB", CH_CR}, 3);
		exp_log({LOG_NOTIFY_FAIL, 1'b1}, 3'h7);
		exp_bytes(STR_HANG, 5);
		quiet(100);
		mode <= 1'b1;
		wb(1'b1, ADDR_CTRL, 32'h0000_0001);
		mode <= 1'b0;
		wb(1'b1, ADDR_G1CFG, 32'h0000_0303);
		reply <= RES_NO_CARRIER;
		call1();
		key <= 1'b1;
		@(posedge clk);
		key <= 1'b0;
		quiet(200);
		call1();
		repeat (12) @(posedge clk);
		reply <= 8'h00;
		inj(RES_RING);
		inj(RES_CONNECT);
		chk(sess, 1'b1);
		for (int k = 0; k < 4; k++)
		begin
			inj(keys[k]);
			chk(show_acc, 32'h1 << k);
		end
		inj(KEY_RESET);
		inj(RES_NO_CARRIER);
		chk(sess, 1'b0);
		quiet(200);
		finish_test();
	end
endmodule // tb_modem_notify_ctrl
